// file: ocsc_top.sv
// How it works
// RQ1 - Slave realigns output clock on every reference edge
// RQ2 - Reference phase clock is the only alignment input
// RQ3 - Output clock delayed by latency plus delay minus adjust
// RQ4 - Demux mode divides sample clock by four
// RQ5 - Reference edge picks slave output clock phase
// RQ6 - Alignment configured only through control register
// RQ7 - Reset pulse off after reset, needs extended mode
// RQ8 - In-phase and quadrature clocks share one source
// RQ9 - Reset pulse accepted at any time
// RQ10 - Held high in demux, toggles in non-demux
// RQ11 - One narrow pulse may appear entering hold
// RQ12 - Phase select high aligns four cycles after release
// RQ13 - Phase select low aligns five cycles after release
// RQ14 - Clock resumes after output delay past aligning edge
// RQ15 - Controller sends dummy pulse then aligning pulse
// RQ16 - Controller programs equal phase selects on masters
// RQ17 - Released reset pulse sampled through synchroniser
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ocsc_defs.svh"

module ocsc_top
  import ocsc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        ref_phase_clk_i,
  input  wire logic        output_clock_reset_pulse_i,
  output logic             in_phase_output_clock_o,
  output logic             quadrature_output_clock_o,
  output logic             ref_phase_clk_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  logic rst_n;
  logic ref_sync;
  logic rst_pulse_sync;

  ocsc_sync u_rst_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (1'b1),
    .q_o     (rst_n)
  );

  ocsc_sync u_ref_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     (ref_phase_clk_i),
    .q_o     (ref_sync)
  );

  // Asynchronous pulse is caught on sample-clock edges, so every device
  // sharing the clock counts the same edges to the aligning one
  ocsc_sync u_pulse_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     (output_clock_reset_pulse_i),
    .q_o     (rst_pulse_sync)
  );                                                    // see RQ9, see RQ17

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic reg_hit(
    input logic [3:0] addr,
    input logic [3:0] ofs
  );
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // Control word into fields; the reset function cannot stand without
  // extended mode, so a write asking for it alone stores it off
  function automatic ocsc_ctrl_s ctrl_decode(
    input logic [31:0] wdata
  );
    ctrl_decode                       = '0;
    ctrl_decode.extended_control_mode = wdata[`OCSC_F_EXT_MODE];
    ctrl_decode.msa_en                = wdata[`OCSC_F_MSA_EN];                       // see RQ6
    ctrl_decode.slave                 = wdata[`OCSC_F_SLAVE];
    ctrl_decode.demux                 = wdata[`OCSC_F_DEMUX];
    ctrl_decode.ddr_phase             = wdata[`OCSC_F_DDR_PHASE];
    ctrl_decode.rst_en                = wdata[`OCSC_F_RST_EN] && wdata[`OCSC_F_EXT_MODE]; // see RQ7
    ctrl_decode.ap_adj                = wdata[`OCSC_F_AP_ADJ_HI:`OCSC_F_AP_ADJ_LO];
  endfunction : ctrl_decode

  // Fields back to their bit positions; the struct order is not the word's
  function automatic logic [31:0] ctrl_word(
    input ocsc_ctrl_s ctrl
  );
    ctrl_word                                      = 32'h0000_0000;
    ctrl_word[`OCSC_F_EXT_MODE]                    = ctrl.extended_control_mode;
    ctrl_word[`OCSC_F_MSA_EN]                      = ctrl.msa_en;
    ctrl_word[`OCSC_F_SLAVE]                       = ctrl.slave;
    ctrl_word[`OCSC_F_DEMUX]                       = ctrl.demux;
    ctrl_word[`OCSC_F_DDR_PHASE]                   = ctrl.ddr_phase;
    ctrl_word[`OCSC_F_RST_EN]                      = ctrl.rst_en;
    ctrl_word[`OCSC_F_AP_ADJ_HI:`OCSC_F_AP_ADJ_LO] = ctrl.ap_adj;
  endfunction : ctrl_word

  function automatic logic [31:0] status_word(
    input ocsc_state_s s
  );
    status_word                                      = 32'h0000_0000;
    status_word[`OCSC_F_HELD]                        = (s.hold != OCSC_HOLD_IDLE);
    status_word[`OCSC_F_COUNTING]                    = (s.hold == OCSC_HOLD_COUNT);
    status_word[`OCSC_F_PHASE_HI:`OCSC_F_PHASE_LO]   = s.phase;
    status_word[`OCSC_F_REF_SEEN]                    = s.ref_seen;
    status_word[`OCSC_F_PULSES_HI:`OCSC_F_PULSES_LO] = s.pulses;
  endfunction : status_word

  // Unmapped addresses read as zero
  function automatic logic [31:0] read_word(
    input logic [3:0]  addr,
    input ocsc_state_s s
  );
    if (reg_hit(addr, `OCSC_CTRL_OFS)) begin
      read_word = ctrl_word(s.ctrl);
    end else if (reg_hit(addr, `OCSC_STATUS_OFS)) begin
      read_word = status_word(s);
    end else begin
      read_word = 32'h0000_0000;
    end
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // Timing selections

  // Latency plus output delay, less the aperture adjust
  function automatic logic [2:0] tap_select(
    input logic [1:0] ap_adj
  );
    tap_select = 3'(`OCSC_PIPE_LAT + `OCSC_OD_CYC) - {1'b0, ap_adj};       // see RQ3
  endfunction : tap_select

  // Edges from the seen release to the aligning edge
  function automatic logic [2:0] align_load(
    input logic ddr_phase
  );
    align_load = ddr_phase ? `OCSC_ALIGN_90 : `OCSC_ALIGN_0;             // see RQ12, see RQ13
  endfunction : align_load

  // Master's phase once its edge is through the synchroniser, led by our
  // own output path so both output clocks land on the same phase
  function automatic logic [1:0] slave_phase(
    input logic [2:0] tap_sel
  );
    slave_phase = `OCSC_PHASE_HIGH + 2'(`OCSC_SYNC_LAT) + 2'(`OCSC_DLY_FIXED) + tap_sel[1:0]; // see RQ5
  endfunction : slave_phase

  // Quarter rate in demux and held high there during a reset pulse;
  // half rate otherwise and never held
  function automatic logic clk_shape(
    input logic       demux,
    input logic       held,
    input logic [1:0] phase
  );
    if (demux) begin
      clk_shape = held ? 1'b1 : phase[1];                              // see RQ4, see RQ10, see RQ11
    end else begin
      clk_shape = phase[0];                                            // see RQ10
    end
  endfunction : clk_shape

  ////////////////////////////////////////////////////////////////////////////
  // State and derived controls

  ocsc_state_s s_r;
  ocsc_state_s s_nxt;
  logic [2:0]  tap;
  logic [1:0]  ref_load;
  logic        ref_rise;
  logic        pulse_on;
  logic        clk_out;

  // Latency plus output delay, less the aperture adjust
  assign tap = tap_select(s_r.ctrl.ap_adj);                                // see RQ3

  // Phase the master's counter holds when its reference edge reaches us, led by our own output path
  assign ref_load = slave_phase(tap);                                      // see RQ5

  assign ref_rise = ref_sync && !s_r.ref_prev;

  // Reset pulse only acts with the function enabled under extended mode
  assign pulse_on = s_r.ctrl.extended_control_mode && s_r.ctrl.rst_en && rst_pulse_sync; // see RQ7

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_nxt       = s_r;
    s_nxt.rdata = 32'h0000_0000;

    // Control register; this is the only way to set up alignment
    if (wr_i && reg_hit(addr_i, `OCSC_CTRL_OFS)) begin
      s_nxt.ctrl = ctrl_decode(wdata_i);                                  // see RQ6, see RQ7
    end

    // Read data stand for the one cycle after the strobe
    if (rd_i) begin
      s_nxt.rdata = read_word(addr_i, s_r);
    end

    // Free-running phase of the divided clock
    s_nxt.phase    = s_r.phase + 2'h1;
    s_nxt.ref_prev = ref_sync;

    // Slave follows the master on every reference edge, no sync pulse needed
    if (s_r.ctrl.msa_en && s_r.ctrl.slave && ref_rise) begin
      s_nxt.phase    = ref_load;                         // see RQ1, see RQ2, see RQ5
      s_nxt.ref_seen = 1'b1;
    end
    if (!s_r.ctrl.msa_en) begin
      s_nxt.ref_seen = 1'b0;
    end

    // Reset pulse hold and release sequence
    case (s_r.hold)
      OCSC_HOLD_IDLE: begin
        if (pulse_on) begin
          s_nxt.hold = OCSC_HOLD_ACTIVE;                     // see RQ9
          if (s_r.pulses != 2'h3) begin
            s_nxt.pulses = s_r.pulses + 2'h1;
          end
        end
      end
      OCSC_HOLD_ACTIVE: begin
        if (!rst_pulse_sync) begin
          s_nxt.hold      = OCSC_HOLD_COUNT;
          s_nxt.align_cnt = align_load(s_r.ctrl.ddr_phase);             // see RQ12, see RQ13
        end
      end
      OCSC_HOLD_COUNT: begin
        if (rst_pulse_sync) begin
          s_nxt.hold = OCSC_HOLD_ACTIVE;
        end else if (s_r.align_cnt == 3'h1) begin
          // Aligning edge: restart the divider on its high phase
          s_nxt.phase = `OCSC_PHASE_HIGH;                  // see RQ12, see RQ13
          s_nxt.hold  = OCSC_HOLD_IDLE;
        end else begin
          s_nxt.align_cnt = s_r.align_cnt - 3'h1;
        end
      end
      default: begin
        s_nxt.hold = OCSC_HOLD_IDLE;
      end
    endcase

    if (!(s_r.ctrl.extended_control_mode && s_r.ctrl.rst_en)) begin
      s_nxt.hold = OCSC_HOLD_IDLE;                           // see RQ7
    end

    // Divided clock before the latency pipe; entering the hold may cut the
    // last low half short
    s_nxt.clk_pre = clk_shape(s_r.ctrl.demux, (s_nxt.hold != OCSC_HOLD_IDLE), s_nxt.phase); // see RQ11
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r           <= '0;
      s_r.ctrl      <= `OCSC_CTRL_RST;                       // see RQ7
      s_r.phase     <= `OCSC_PHASE_RST;
      s_r.hold      <= OCSC_HOLD_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latency and delay

  // Resumed clock appears only after the pipe and output delay
  ocsc_delay_line u_dly (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     (s_r.clk_pre),
    .tap_i   (tap),
    .q_o     (clk_out)
  );                                                     // see RQ3, see RQ14

  // Both channel clocks come from one flop, always in step
  assign in_phase_output_clock_o   = clk_out;              // see RQ8
  assign quadrature_output_clock_o = clk_out;              // see RQ8
  assign ref_phase_clk_o           = clk_out;
  assign rdata_o                   = s_r.rdata;

endmodule : ocsc_top

`default_nettype wire

// file: ocsc_defs.svh
`ifndef OCSC_DEFS_SVH
`define OCSC_DEFS_SVH

// Register byte offsets
`define OCSC_CTRL_OFS        4'h0
`define OCSC_STATUS_OFS      4'h4

// Control register fields
`define OCSC_F_EXT_MODE      0
`define OCSC_F_MSA_EN        1
`define OCSC_F_SLAVE         2
`define OCSC_F_DEMUX         3
`define OCSC_F_DDR_PHASE     4
`define OCSC_F_RST_EN        5
`define OCSC_F_AP_ADJ_LO     6
`define OCSC_F_AP_ADJ_HI     7

// Status register fields
`define OCSC_F_HELD          0
`define OCSC_F_COUNTING      1
`define OCSC_F_PHASE_LO      2
`define OCSC_F_PHASE_HI      3
`define OCSC_F_REF_SEEN      4
`define OCSC_F_PULSES_LO     5
`define OCSC_F_PULSES_HI     6

// Reset values
`define OCSC_CTRL_RST        8'h00
`define OCSC_PHASE_RST       2'h0

// Timing
`define OCSC_CLK_NS          50
`define OCSC_OD_NS           100
`define OCSC_OD_CYC          ((`OCSC_OD_NS + `OCSC_CLK_NS - 1) / `OCSC_CLK_NS)
`define OCSC_PIPE_LAT        3
`define OCSC_DLY_DEPTH       8
`define OCSC_DLY_FIXED       2
`define OCSC_ALIGN_90        3'h4
`define OCSC_ALIGN_0         3'h5
`define OCSC_SYNC_LAT        3
`define OCSC_PHASE_HIGH      2'h2

`endif

// file: ocsc_pkg.sv
package ocsc_pkg;

  typedef enum logic [1:0] {
    OCSC_HOLD_IDLE,
    OCSC_HOLD_ACTIVE,
    OCSC_HOLD_COUNT
  } ocsc_hold_e;

  typedef struct packed {
    logic       extended_control_mode;
    logic       msa_en;
    logic       slave;
    logic       demux;
    logic       ddr_phase;
    logic       rst_en;
    logic [1:0] ap_adj;
  } ocsc_ctrl_s;

  typedef struct packed {
    ocsc_ctrl_s  ctrl;
    logic [1:0]  phase;
    logic        ref_prev;
    ocsc_hold_e  hold;
    logic [2:0]  align_cnt;
    logic        ref_seen;
    logic [1:0]  pulses;
    logic        clk_pre;
    logic [31:0] rdata;
  } ocsc_state_s;

endpackage : ocsc_pkg

// file: ocsc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ocsc_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : ocsc_sync

`default_nettype wire

// file: ocsc_delay_line.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocsc_defs.svh"

module ocsc_delay_line (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       d_i,
  input  wire logic [2:0] tap_i,
  output logic            q_o
);

  logic [`OCSC_DLY_DEPTH-1:0] line_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_r[0] <= 1'b0;
    end else begin
      line_r[0] <= d_i;
    end
  end

  // Shift stages of the latency pipe
  genvar g;
  generate
    for (g = 1; g < `OCSC_DLY_DEPTH; g++) begin : g_stage
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          line_r[g] <= 1'b0;
        end else begin
          line_r[g] <= line_r[g-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= 1'b0;
    end else begin
      q_o <= line_r[tap_i];
    end
  end

endmodule : ocsc_delay_line

`default_nettype wire

// file: ocsc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ocsc_top_asserts (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        ref_phase_clk_i,
  input wire logic        output_clock_reset_pulse_i,
  input wire logic        in_phase_output_clock_o,
  input wire logic        quadrature_output_clock_o,
  input wire logic        ref_phase_clk_o
);
  logic [7:0] c_r;
  logic [4:0] w_r;
  logic       en;
  assign en = c_r[0] & c_r[5];
  // Shadow of the control byte, cycles since the last write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_r <= 8'h00;
      w_r <= 5'h00;
    end else begin
      if (wr_i && addr_i == 4'h0) c_r <= wdata_i[7:0];
      w_r <= wr_i ? 5'h00 : w_r + {4'h0, w_r != 5'h1f};
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_held;
    output_clock_reset_pulse_i [*8] ##1 output_clock_reset_pulse_i [*5];
  endsequence
  a_iq_same: assert property (in_phase_output_clock_o == quadrature_output_clock_o)
    else $error("I and Q clocks differ");
  a_ref_copy: assert property (ref_phase_clk_o == in_phase_output_clock_o)
    else $error("reference out differs from clock");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_ctrl_read: assert property ($past(rd_i) && $past(addr_i) == 4'h0 |->
    rdata_o == {24'h0, c_r[7:6], en, c_r[4:0]}) else $error("control readback wrong");
  a_rst_quiet: assert property ($rose(rst_n_i) |-> !in_phase_output_clock_o [*3])
    else $error("clock before pipeline filled");
  a_demux_duty: assert property (w_r == 5'h1f && c_r[3] && !c_r[2] && !en &&
    $rose(in_phase_output_clock_o) |=> in_phase_output_clock_o ##1 !in_phase_output_clock_o [*2])
    else $error("demux clock not two high two low");
  a_hold_high: assert property (s_held ##0 (en && c_r[3] && !c_r[2]) |-> in_phase_output_clock_o)
    else $error("clock not held high");
  a_nodemux_run: assert property (s_held ##0 (en && !c_r[3] && !c_r[2] && w_r == 5'h1f) |->
    in_phase_output_clock_o != $past(in_phase_output_clock_o)) else $error("clock stopped");
endmodule : ocsc_top_asserts
bind ocsc_top ocsc_top_asserts u_chk (
  .clk_i                      (clk_i),
  .rst_n_i                    (rst_n_i),
  .addr_i                     (addr_i),
  .wdata_i                    (wdata_i),
  .wr_i                       (wr_i),
  .rd_i                       (rd_i),
  .rdata_o                    (rdata_o),
  .ref_phase_clk_i            (ref_phase_clk_i),
  .output_clock_reset_pulse_i (output_clock_reset_pulse_i),
  .in_phase_output_clock_o    (in_phase_output_clock_o),
  .quadrature_output_clock_o  (quadrature_output_clock_o),
  .ref_phase_clk_o            (ref_phase_clk_o)
);
`default_nettype wire

// file: ocsc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocsc_master_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic slip_i,
  output logic      ref_o
);
  logic [1:0] cnt_r;
  // Quarter-rate master clock; a slip stands for an upset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_r <= 2'h0;
    else if (!slip_i) cnt_r <= cnt_r + 2'h1;
  end
  assign ref_o = cnt_r[1];
endmodule : ocsc_master_model
`default_nettype wire

// file: ocsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ocsc_top_tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        output_clock_reset_pulse_i = 1'b0;
  logic        slip = 1'b0;
  logic [31:0] rdata_o;
  logic        ref_phase_clk_i, in_phase_output_clock_o, quadrature_output_clock_o, ref_phase_clk_o;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n90, n0, na;
  ocsc_top DUT (
    .clk_i                      (clk_i),
    .rst_n_i                    (rst_n_i),
    .addr_i                     (addr_i),
    .wdata_i                    (wdata_i),
    .wr_i                       (wr_i),
    .rd_i                       (rd_i),
    .rdata_o                    (rdata_o),
    .ref_phase_clk_i            (ref_phase_clk_i),
    .output_clock_reset_pulse_i (output_clock_reset_pulse_i),
    .in_phase_output_clock_o    (in_phase_output_clock_o),
    .quadrature_output_clock_o  (quadrature_output_clock_o),
    .ref_phase_clk_o            (ref_phase_clk_o)
  );
  ocsc_master_model u_master (.clk_i(clk_i), .rst_n_i(rst_n_i), .slip_i(slip), .ref_o(ref_phase_clk_i));
  initial forever #25 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= {24'h0, d};
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", rdata_o, e);
    @(posedge clk_i);
  endtask : rd
  // Holds the pulse, then counts edges from release to the aligned fall
  task automatic pulse(output int n);
    output_clock_reset_pulse_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    output_clock_reset_pulse_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (in_phase_output_clock_o !== 1'b0 && n < 40);
    repeat (8) @(posedge clk_i);
  endtask : pulse
  task automatic match(input int k);
    repeat (k) @(posedge clk_i);
    repeat (8) begin
      @(posedge clk_i);
      #1;
      chk("slave_clk", 32'(in_phase_output_clock_o), 32'(ref_phase_clk_i));
    end
  endtask : match
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    wr(4'h0, 8'h20);
    rd(4'h0, 32'h0);
    $display("register test done");
    wr(4'h0, 8'h08);
    repeat (40) @(posedge clk_i);
    pulse(n0);
    chk("pulse_ignored", 32'(n0 <= 4), 32'h1);
    wr(4'h0, 8'h39);
    rd(4'h0, 32'h39);
    pulse(n90);
    pulse(n90);
    // 3 edges to take the release, 4 counted, 2 to the low half, 7 through the pipe
    chk("align_90", 32'(n90), 32'h10);
    wr(4'h0, 8'h29);
    pulse(n0);
    pulse(n0);
    chk("align_0", 32'(n0), 32'(n90 + 1));
    wr(4'h0, 8'he9);
    pulse(na);
    pulse(na);
    chk("ap_adjust", 32'(na), 32'(n0 - 3));
    wr(4'h0, 8'h21);
    repeat (20) @(posedge clk_i);
    pulse(na);
    chk("nodemux_runs", 32'(na <= 2), 32'h1);
    $display("reset pulse test done");
    wr(4'h0, 8'h0e);
    match(40);
    @(posedge clk_i);
    slip <= 1'b1;
    @(posedge clk_i);
    slip <= 1'b0;
    match(16);
    $display("slave test done");
    report_and_stop();
  end
  initial begin
    #(50 * 4000);
    n_errors++;
    report_and_stop();
  end
endmodule : ocsc_top_tb
`default_nettype wire
